/* design/mocl_pkg.sv */
package mocl_pkg;
  // protection phases
  typedef enum logic [1:0] {MOCL_OFF, MOCL_PEAK, MOCL_CLAMP} mocl_state_e;
  // a current in milliamperes
  typedef logic [15:0] mocl_cur_t;
endpackage : mocl_pkg

/* design/mocl_regs.svh */
`ifndef MOCL_REGS_SVH
`define MOCL_REGS_SVH
// register byte offsets
`define MOCL_ADDR_CTRL 8'h00
`define MOCL_ADDR_MAXCUR 8'h04
`define MOCL_ADDR_RATED 8'h08
`define MOCL_ADDR_PEAK 8'h0c
`define MOCL_ADDR_DUR 8'h10
`define MOCL_ADDR_LIMIT 8'h14
`define MOCL_ADDR_ACCUM 8'h18
`define MOCL_ADDR_APPLIED 8'h1c
`define MOCL_ADDR_STATUS 8'h20
`define MOCL_ADDR_IRQ_STAT 8'h24
`define MOCL_ADDR_IRQ_MASK 8'h28
// field positions
`define MOCL_CTRL_CLOSED_LOOP 0
`define MOCL_IRQ_CLAMP 0
`define MOCL_IRQ_RELEASE 1
// reset values
`define MOCL_RST_CUR 16'h0000
`define MOCL_RST_DUR 16'h0000
// scaling, timing and response codes
`define MOCL_PERMILLE 32'd1000
`define MOCL_TICK_US 1000
`define MOCL_CLK_MHZ 25
`define MOCL_RESP_OKAY 2'b00
`define MOCL_RESP_SLVERR 2'b10
`endif

/* design/mocl_top.sv */
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "mocl_regs.svh"
module mocl_top #(
  parameter int TICK_CYC = `MOCL_TICK_US * `MOCL_CLK_MHZ,
  parameter int ACC_W = 48
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire mocl_pkg::mocl_cur_t MEAS_CURRENT,
  output mocl_pkg::mocl_cur_t CURRENT_LIMIT,
  output logic PROT_ACTIVE,
  output logic IRQ
);
  import mocl_pkg::*;

  // write channel holding registers
  logic aw_hold_r;
  logic [7:0] awaddr_r;
  logic w_hold_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // read channel registers
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // configuration registers
  logic closed_loop_r;
  mocl_cur_t maxcur_r;
  mocl_cur_t rated_r;
  logic [15:0] peak_r;
  logic [15:0] dur_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  // protection state
  mocl_state_e state_r;
  mocl_state_e state_nxt;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] limit_r;
  mocl_cur_t applied_r;
  mocl_cur_t applied_nxt;
  logic [31:0] tick_cnt_r;
  logic tick;

  // write fires once address and data are both held
  wire do_write = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire wr_ctrl = do_write & (awaddr_r == `MOCL_ADDR_CTRL);
  wire wr_maxcur = do_write & (awaddr_r == `MOCL_ADDR_MAXCUR);
  wire wr_rated = do_write & (awaddr_r == `MOCL_ADDR_RATED);
  wire wr_peak = do_write & (awaddr_r == `MOCL_ADDR_PEAK);
  wire wr_dur = do_write & (awaddr_r == `MOCL_ADDR_DUR);
  wire wr_istat = do_write & (awaddr_r == `MOCL_ADDR_IRQ_STAT);
  wire wr_imask = do_write & (awaddr_r == `MOCL_ADDR_IRQ_MASK);
  wire wr_ro = (awaddr_r == `MOCL_ADDR_LIMIT) | (awaddr_r == `MOCL_ADDR_ACCUM) |
               (awaddr_r == `MOCL_ADDR_APPLIED) | (awaddr_r == `MOCL_ADDR_STATUS);
  wire wr_hit = wr_ctrl | wr_maxcur | wr_rated | wr_peak | wr_dur | wr_istat | wr_imask |
                (do_write & wr_ro);
  // merged write data per byte lane
  wire [31:0] wr_ctrl_v = ({31'h0, closed_loop_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] wr_max_v = ({16'h0, maxcur_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] wr_rat_v = ({16'h0, rated_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] wr_pk_v = ({16'h0, peak_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] wr_dur_v = ({16'h0, dur_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] wr_msk_v = ({30'h0, irq_mask_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] w1c_v = wdata_r & wmask;

  // peak current from rated and permille setting, capped by the ceiling
  wire [31:0] peak_prod = rated_r * peak_r;
  wire [31:0] peak_raw = peak_prod / `MOCL_PERMILLE;
  wire [15:0] peak_sat = (|peak_raw[31:16]) ? 16'hffff : peak_raw[15:0];
  wire [15:0] peak_eff = (peak_sat > maxcur_r) ? maxcur_r : peak_sat;
  // enable needs closed loop, real excess and a duration
  wire enable = closed_loop_r & (peak_eff > rated_r) & (dur_r != 16'h0);
  // squared currents
  wire [31:0] rated_sq = rated_r * rated_r;
  wire [31:0] peak_sq = peak_eff * peak_eff;
  wire [31:0] meas_sq = MEAS_CURRENT * MEAS_CURRENT;
  // limit is excess energy allowed over the peak duration
  wire [31:0] lim_excess = peak_sq - rated_sq;
  wire [47:0] lim_calc = lim_excess * dur_r;
  // per-tick accumulator step
  wire over = meas_sq > rated_sq;
  wire [31:0] up_step = meas_sq - rated_sq;
  wire [32:0] dn_step = {1'b0, rated_sq - meas_sq} + 33'h1;
  wire [ACC_W:0] acc_up = {1'b0, acc_r} + (ACC_W+1)'(up_step);
  wire [ACC_W-1:0] acc_up_sat = acc_up[ACC_W] ? '1 : acc_up[ACC_W-1:0];
  wire [ACC_W-1:0] dn_ext = (ACC_W)'(dn_step);
  wire [ACC_W-1:0] acc_dn_sat = (acc_r > dn_ext) ? acc_r - dn_ext : '0;
  // saturated 32-bit views for software
  wire [31:0] lim_rd = (|limit_r[ACC_W-1:32]) ? 32'hffffffff : limit_r[31:0];
  wire [31:0] acc_rd = (|acc_r[ACC_W-1:32]) ? 32'hffffffff : acc_r[31:0];

  // read decode
  wire [31:0] rd_data =
    (S_AXI_ARADDR == `MOCL_ADDR_CTRL) ? {31'h0, closed_loop_r} :
    (S_AXI_ARADDR == `MOCL_ADDR_MAXCUR) ? {16'h0, maxcur_r} :
    (S_AXI_ARADDR == `MOCL_ADDR_RATED) ? {16'h0, rated_r} :
    (S_AXI_ARADDR == `MOCL_ADDR_PEAK) ? {16'h0, peak_r} :
    (S_AXI_ARADDR == `MOCL_ADDR_DUR) ? {16'h0, dur_r} :
    (S_AXI_ARADDR == `MOCL_ADDR_LIMIT) ? lim_rd :
    (S_AXI_ARADDR == `MOCL_ADDR_ACCUM) ? acc_rd :
    (S_AXI_ARADDR == `MOCL_ADDR_APPLIED) ? {16'h0, applied_r} :
    (S_AXI_ARADDR == `MOCL_ADDR_STATUS) ? {31'h0, state_r != MOCL_OFF} :
    (S_AXI_ARADDR == `MOCL_ADDR_IRQ_STAT) ? {30'h0, irq_stat_r} :
    (S_AXI_ARADDR == `MOCL_ADDR_IRQ_MASK) ? {30'h0, irq_mask_r} : 32'h0;
  wire rd_hit = (S_AXI_ARADDR <= `MOCL_ADDR_IRQ_MASK) & (S_AXI_ARADDR[1:0] == 2'b00);

  // handshake outputs
  assign S_AXI_AWREADY = ~aw_hold_r;
  assign S_AXI_WREADY = ~w_hold_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign CURRENT_LIMIT = applied_r;
  assign PROT_ACTIVE = (state_r != MOCL_OFF);
  assign IRQ = |(irq_stat_r & irq_mask_r);
  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

  // write address capture
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (S_AXI_AWVALID & ~aw_hold_r) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_hold_r <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (S_AXI_WVALID & ~w_hold_r) begin
      w_hold_r <= 1'b1;
      wdata_r <= S_AXI_WDATA;
      wstrb_r <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_hold_r <= 1'b0;
    end
  end

  // write response, error on unmapped offsets
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      bvalid_r <= 1'b0;
      bresp_r <= `MOCL_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `MOCL_RESP_OKAY : `MOCL_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `MOCL_RESP_OKAY;
    end else if (S_AXI_ARVALID & ~rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_hit ? `MOCL_RESP_OKAY : `MOCL_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      closed_loop_r <= 1'b0;
      maxcur_r <= `MOCL_RST_CUR;
      rated_r <= `MOCL_RST_CUR;
      peak_r <= `MOCL_RST_CUR;
      dur_r <= `MOCL_RST_DUR;
      irq_mask_r <= 2'h0;
    end else begin
      if (wr_ctrl) closed_loop_r <= wr_ctrl_v[`MOCL_CTRL_CLOSED_LOOP];
      if (wr_maxcur) maxcur_r <= wr_max_v[15:0];
      if (wr_rated) rated_r <= wr_rat_v[15:0];
      if (wr_peak) peak_r <= wr_pk_v[15:0];
      if (wr_dur) dur_r <= wr_dur_v[15:0];
      if (wr_imask) irq_mask_r <= wr_msk_v[1:0];
    end
  end

  // sticky events; a new event wins over a one-to-clear
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r[`MOCL_IRQ_CLAMP] <= (state_nxt == MOCL_CLAMP && state_r == MOCL_PEAK) |
        (irq_stat_r[`MOCL_IRQ_CLAMP] & ~(wr_istat & w1c_v[`MOCL_IRQ_CLAMP]));
      irq_stat_r[`MOCL_IRQ_RELEASE] <= (state_nxt == MOCL_PEAK && state_r == MOCL_CLAMP) |
        (irq_stat_r[`MOCL_IRQ_RELEASE] & ~(wr_istat & w1c_v[`MOCL_IRQ_RELEASE]));
    end
  end

  // control cycle divider
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  // accumulator next value, cleared while disabled
  always_comb begin
    acc_nxt = acc_r;
    if (!enable) begin
      acc_nxt = '0;
    end else if (tick) begin
      acc_nxt = over ? acc_up_sat : acc_dn_sat;
    end
  end

  // protection phase and applied limit
  always_comb begin
    state_nxt = state_r;
    applied_nxt = maxcur_r;
    case (state_r)
      MOCL_OFF: begin
        if (enable) state_nxt = MOCL_PEAK;
      end
      MOCL_PEAK: begin
        if (!enable) state_nxt = MOCL_OFF;
        else if (acc_nxt >= ACC_W'(lim_calc)) state_nxt = MOCL_CLAMP;
      end
      MOCL_CLAMP: begin
        if (!enable) state_nxt = MOCL_OFF;
        else if (acc_nxt < ACC_W'(lim_calc)) state_nxt = MOCL_PEAK;
      end
      default: state_nxt = MOCL_OFF;
    endcase
    case (state_nxt)
      MOCL_PEAK: applied_nxt = peak_eff;
      MOCL_CLAMP: applied_nxt = rated_r;
      default: applied_nxt = maxcur_r;
    endcase
  end

  // protection registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= MOCL_OFF;
      acc_r <= '0;
      limit_r <= '0;
      applied_r <= `MOCL_RST_CUR;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      limit_r <= enable ? ACC_W'(lim_calc) : '0;
      applied_r <= applied_nxt;
    end
  end
endmodule : mocl_top
`default_nettype wire

/* testbench/mocl_loop_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mocl_loop_model (
  input wire mocl_pkg::mocl_cur_t demand,
  input wire mocl_pkg::mocl_cur_t limit,
  output wire mocl_pkg::mocl_cur_t meas
);
  import mocl_pkg::*;
  // current loop follows demand but never exceeds the granted limit
  assign meas = (demand > limit) ? limit : demand;
endmodule : mocl_loop_model
`default_nettype wire

/* testbench/mocl_top_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mocl_regs.svh"
module mocl_top_assertions (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // single domain, reset silences all checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // address and data accepted together
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // read address accepted
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> ##2 S_AXI_BVALID)
    else $error("write response not two edges after acceptance");
  chk_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID)
    else $error("read data not raised on acceptance");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped or changed early");
  chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped or changed early");
  chk_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address ready while data pending");
  // address and data stay refused while both are held for the write
  chk_aw_blocked: assert property (s_wr_taken |=> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write ready while address and data held");
  chk_slverr_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == `MOCL_RESP_SLVERR |->
    S_AXI_RDATA == 32'h0)
    else $error("error read returned nonzero data");
  chk_read_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data held after handshake");
endmodule : mocl_top_assertions
bind mocl_top mocl_top_assertions i_mocl_top_assertions (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

/* testbench/mocl_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mocl_regs.svh"
module mocl_top_tb;
  import mocl_pkg::*;
  logic clk, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0; // bus drive
  logic [7:0] awa = 8'h00, ara = 8'h00; // addresses
  logic [31:0] wd = 32'h0, got; // write and read data
  logic [1:0] resp; // last response code
  wire logic awr, wr, bv, arr, rv, irq, act;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rd;
  wire mocl_cur_t lim, meas;
  mocl_cur_t demand = 16'h0000; // current the loop asks for
  int error_cnt, checks_done, n_fast, n_slow;
  // one register access: address, write data, read back, response
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} mocl_row_s;
  mocl_row_s rows [9] = '{'{`MOCL_ADDR_MAXCUR, 32'h1234_03e8, 32'h3e8, `MOCL_RESP_OKAY},
    '{`MOCL_ADDR_RATED, 32'h190, 32'h190, `MOCL_RESP_OKAY}, '{`MOCL_ADDR_PEAK, 32'h7d0, 32'h7d0, `MOCL_RESP_OKAY},
    '{`MOCL_ADDR_DUR, 32'h3, 32'h3, `MOCL_RESP_OKAY}, '{`MOCL_ADDR_IRQ_MASK, 32'hfffd, 32'h1, `MOCL_RESP_OKAY},
    '{`MOCL_ADDR_STATUS, 32'h1, 32'h0, `MOCL_RESP_OKAY}, '{`MOCL_ADDR_LIMIT, 32'h5, 32'h0, `MOCL_RESP_OKAY},
    '{8'h2c, 32'h5, 32'h0, `MOCL_RESP_SLVERR}, '{8'h06, 32'h5, 32'h0, `MOCL_RESP_SLVERR}};
  mocl_top #(.TICK_CYC(8)) i_mocl_top (.SYS_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .MEAS_CURRENT(meas), .CURRENT_LIMIT(lim), .PROT_ACTIVE(act), .IRQ(irq));
  mocl_loop_model i_mocl_loop_model (.demand(demand), .limit(lim), .meas(meas));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_word
  task automatic cmp_cur(input mocl_cur_t g, input mocl_cur_t e);
    cmp_word({16'h0, g}, {16'h0, e});
  endtask : cmp_cur
  task automatic cmp_bit(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask : cmp_bit
  // write: both channels offered, each released once taken
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv;
      resp = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    bre <= 1'b0;
    // idle edge, so a following call never re-raises bready in the same step
    @(posedge clk);
  endtask : bus_wr
  // read: address held until taken, data taken at the handshake edge
  task automatic bus_rd(input logic [7:0] a);
    logic tr, tv;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(negedge clk);
      tr = arv && arr;
      tv = rv;
      got = rd;
      resp = rresp;
      @(posedge clk);
      if (tr) arv <= 1'b0;
    end while (!tv);
    rre <= 1'b0;
    // idle edge, so a following call never re-raises rready in the same step
    @(posedge clk);
  endtask : bus_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a);
    cmp_word(got, e);
  endtask : rd_chk
  // wait bounded for the applied limit, compare before the next edge
  task automatic wait_lim(input mocl_cur_t e, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lim !== e && n < 300);
    cmp_cur(lim, e);
    @(posedge clk);
  endtask : wait_lim
  // status and interrupt pins at a settled point
  task automatic pins_chk(input logic a, input logic i);
    @(negedge clk);
    cmp_bit(act, a);
    cmp_bit(irq, i);
    @(posedge clk);
  endtask : pins_chk
  // enable, see peak granted, time the clamp
  task automatic run_peak(output int n);
    int k;
    bus_wr(`MOCL_ADDR_CTRL, 32'h1);
    wait_lim(16'd800, k);
    rd_chk(`MOCL_ADDR_APPLIED, 32'd800);
    wait_lim(16'd400, n);
  endtask : run_peak
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // hang guard, far beyond the few hundred cycles expected
  initial begin
    #800000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    pins_chk(1'b0, 1'b0);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      bus_wr(rows[i].a, rows[i].d);
      cmp_word({30'h0, resp}, {30'h0, rows[i].r});
      rd_chk(rows[i].a, rows[i].e);
      cmp_word({30'h0, resp}, {30'h0, rows[i].r});
    end
    $display("register table done");
    demand <= 16'd800;
    run_peak(n_fast);
    demand <= 16'd0;
    wait_lim(16'd800, n_slow);
    pins_chk(1'b1, 1'b1);
    rd_chk(`MOCL_ADDR_LIMIT, 32'd1440000);
    rd_chk(`MOCL_ADDR_IRQ_STAT, 32'h3);
    bus_wr(`MOCL_ADDR_IRQ_STAT, 32'h1);
    pins_chk(1'b1, 1'b0);
    rd_chk(`MOCL_ADDR_IRQ_STAT, 32'h2);
    $display("clamp and release done");
    bus_wr(`MOCL_ADDR_CTRL, 32'h0);
    wait_lim(16'd1000, n_slow);
    pins_chk(1'b0, 1'b0);
    demand <= 16'd600;
    run_peak(n_slow);
    cmp_bit(n_fast < n_slow, 1'b1);
    $display("excess rate done");
    demand <= 16'd0;
    bus_wr(`MOCL_ADDR_CTRL, 32'h0);
    bus_wr(`MOCL_ADDR_MAXCUR, 32'd600);
    bus_wr(`MOCL_ADDR_CTRL, 32'h1);
    wait_lim(16'd600, n_slow);
    rd_chk(`MOCL_ADDR_STATUS, 32'h1);
    rd_chk(`MOCL_ADDR_APPLIED, 32'd600);
    rd_chk(`MOCL_ADDR_LIMIT, 32'd600000);
    rd_chk(`MOCL_ADDR_ACCUM, 32'h0);
    bus_wr(`MOCL_ADDR_PEAK, 32'd900);
    rd_chk(`MOCL_ADDR_STATUS, 32'h0);
    rd_chk(`MOCL_ADDR_LIMIT, 32'h0);
    $display("ceiling and invalid setup done");
    nrst <= 1'b0;
    wait_lim(16'h0, n_slow);
    pins_chk(1'b0, 1'b0);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(`MOCL_ADDR_MAXCUR, 32'h0);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule : mocl_top_tb
`default_nettype wire
